// File: core/mbr_pkg.sv
// package: constants for the read-only register query handler
package mbr_pkg;
  localparam logic [15:0] TCP_PORT = 16'h01F6;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h007D;
  localparam logic [15:0] REG_LAST = 16'h00FF;
  localparam int AREA_BYTES = 512;
  localparam int REQ_LEN = 6;
  localparam int IDX_FUNC = 0;
  localparam int IDX_ADDR_HI = 1;
  localparam int IDX_ADDR_LO = 2;
  localparam int IDX_QTY_HI = 3;
  localparam int IDX_QTY_LO = 4;
endpackage : mbr_pkg

// File: core/mbr_server.sv
// design: read-only register query handler (function 3 and 4 PDUs)
module mbr_server #(
  parameter int AREA_BYTES = mbr_pkg::AREA_BYTES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] rx_port,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic [15:0] tx_port,
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [8:0] area_addr,
  output logic area_sel_out,
  input wire logic [7:0] area_rdata,
  input wire logic [15:0] in_size,
  input wire logic [15:0] out_size,
  input wire logic ctl_stat_en,
  input wire logic [15:0] status_word,
  input wire logic [15:0] control_word
);
  typedef enum logic [2:0] {
    S_RECV,
    S_DROP,
    S_CHECK,
    S_HEAD,
    S_DATA
  } mbr_state_e;

  // receive side
  mbr_state_e state_q;
  logic [7:0] req_q [mbr_pkg::REQ_LEN];
  logic [2:0] rcnt_q;
  logic port_ok_q;
  logic rx_take;
  logic first_byte;
  logic port_hit;
  logic frame_full;
  logic frame_good;

  // decoded query fields
  logic [7:0] func;
  logic [15:0] start;
  logic [15:0] qty;
  logic [16:0] last_reg;
  logic [15:0] size_bytes;
  logic [16:0] need_bytes;
  logic func_ok;
  logic qty_ok;
  logic range_ok;
  logic [7:0] check_exc;

  // reply side
  logic [7:0] exc_q;
  logic [1:0] hcnt_q;
  logic [7:0] remain_q;
  logic [15:0] reg_q;
  logic hi_q;
  logic tx_take;
  logic is_exc;
  logic hdr_last;
  logic data_last;
  logic [7:0] hdr_byte;
  logic [7:0] data_byte;
  logic [15:0] cs_word;
  logic cs_hit;

  assign func = req_q[mbr_pkg::IDX_FUNC];
  assign start = {req_q[mbr_pkg::IDX_ADDR_HI], req_q[mbr_pkg::IDX_ADDR_LO]};
  assign qty = {req_q[mbr_pkg::IDX_QTY_HI], req_q[mbr_pkg::IDX_QTY_LO]};

  // 17 bits so a start near the top cannot wrap into a legal range
  assign last_reg = {1'b0, start} + {1'b0, qty} - 17'h00001;
  assign need_bytes = {last_reg[15:0], 1'b0} + 17'h00002;
  assign size_bytes = (func == mbr_pkg::FC_READ_INPUT) ? in_size : out_size;

  assign func_ok = (func == mbr_pkg::FC_READ_INPUT) ||
                   (func == mbr_pkg::FC_READ_HOLD);
  assign qty_ok = (qty >= mbr_pkg::QTY_MIN) && (qty <= mbr_pkg::QTY_MAX);

  // a size input above the area is clipped to what the area holds
  assign range_ok = (last_reg <= {1'b0, mbr_pkg::REG_LAST}) &&
                    (need_bytes <= {1'b0, size_bytes}) &&
                    (need_bytes <= 17'(AREA_BYTES));

  // priority: function, then quantity, then address
  always_comb begin
    check_exc = 8'h00;
    if (!func_ok) begin
      check_exc = mbr_pkg::EXC_FUNC;
    end else if (!qty_ok) begin
      check_exc = mbr_pkg::EXC_VALUE;
    end else if (!range_ok) begin
      check_exc = mbr_pkg::EXC_ADDR;
    end
  end

  assign rx_ready = (state_q == S_RECV) || (state_q == S_DROP);
  assign rx_take = rx_valid && rx_ready;
  assign first_byte = (rcnt_q == 3'h0);
  assign port_hit = (rx_port == mbr_pkg::TCP_PORT);
  assign frame_full = (rcnt_q == 3'(mbr_pkg::REQ_LEN - 2));
  assign frame_good = frame_full && (first_byte ? port_hit : port_ok_q);

  // port is judged once, on the first byte of each frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_ok_q <= 1'b0;
    end else if (rx_take && first_byte) begin
      port_ok_q <= port_hit;
    end
  end

  // count saturates so an over-long frame cannot wrap back to a good length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= 3'h0;
    end else if (rx_take) begin
      if (rx_last) begin
        rcnt_q <= 3'h0;
      end else if (rcnt_q != 3'(mbr_pkg::REQ_LEN)) begin
        rcnt_q <= rcnt_q + 3'h1;
      end
    end
  end

  // request capture; short or foreign-port frames are dropped whole
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mbr_pkg::REQ_LEN; i++) begin
        req_q[i] <= 8'h00;
      end
    end else if (rx_take && rcnt_q < 3'(mbr_pkg::REQ_LEN)) begin
      req_q[rcnt_q] <= rx_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_RECV;
    end else begin
      unique case (state_q)
        S_RECV: begin
          if (rx_valid && rx_last) begin
            // frame is 5 pdu bytes; anything else gets no reply
            if (frame_good) begin
              state_q <= S_CHECK;
            end
          end else if (rx_valid && frame_full) begin
            state_q <= S_DROP;
          end
        end
        S_DROP: begin
          if (rx_valid && rx_last) begin
            state_q <= S_RECV;
          end
        end
        S_CHECK: begin
          state_q <= S_HEAD;
        end
        S_HEAD: begin
          if (tx_take && tx_last) begin
            state_q <= S_RECV;
          end else if (tx_take && hcnt_q == 2'h1) begin
            state_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_take && tx_last) begin
            state_q <= S_RECV;
          end
        end
        default: begin
          state_q <= S_RECV;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exc_q <= 8'h00;
    end else if (state_q == S_CHECK) begin
      exc_q <= check_exc;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 2'h0;
    end else if (state_q == S_CHECK) begin
      hcnt_q <= 2'h0;
    end else if (state_q == S_HEAD && tx_take) begin
      hcnt_q <= hcnt_q + 2'h1;
    end
  end

  // walk through registers; high byte (offset 2n+1) goes first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_q <= 16'h0000;
      hi_q <= 1'b1;
      remain_q <= 8'h00;
    end else if (state_q == S_CHECK) begin
      reg_q <= start;
      hi_q <= 1'b1;
      remain_q <= qty[7:0];
    end else if (state_q == S_DATA && tx_take) begin
      hi_q <= ~hi_q;
      if (!hi_q) begin
        reg_q <= reg_q + 16'h0001;
        remain_q <= remain_q - 8'h01;
      end
    end
  end

  // read only: the area port has no write strobe at all
  assign area_sel_out = (func == mbr_pkg::FC_READ_HOLD);
  assign area_addr = {reg_q[7:0], hi_q};
  assign cs_word = (func == mbr_pkg::FC_READ_INPUT) ? status_word : control_word;
  assign cs_hit = ctl_stat_en && (reg_q == 16'h0000);

  always_comb begin
    if (cs_hit) begin
      data_byte = hi_q ? cs_word[15:8] : cs_word[7:0];
    end else begin
      data_byte = area_rdata;
    end
  end

  assign is_exc = (exc_q != 8'h00);

  always_comb begin
    hdr_byte = 8'h00;
    unique case (hcnt_q)
      2'h0: begin
        hdr_byte = is_exc ? (func | mbr_pkg::EXC_FLAG) : func;
      end
      2'h1: begin
        hdr_byte = is_exc ? exc_q : {qty[6:0], 1'b0};
      end
      default: begin
        hdr_byte = 8'h00;
      end
    endcase
  end

  // exception replies end after the code byte
  assign hdr_last = (hcnt_q == 2'h1) && is_exc;
  assign data_last = !hi_q && (remain_q == 8'h01);

  always_comb begin
    unique case (state_q)
      S_HEAD: begin
        tx_last = hdr_last;
      end
      S_DATA: begin
        tx_last = data_last;
      end
      default: begin
        tx_last = 1'b0;
      end
    endcase
  end

  assign tx_valid = (state_q == S_HEAD) || (state_q == S_DATA);
  assign tx_take = tx_valid && tx_ready;
  assign tx_data = (state_q == S_DATA) ? data_byte : hdr_byte;
  assign tx_port = mbr_pkg::TCP_PORT;
endmodule : mbr_server

// File: tb/mbr_area_model.sv
// partner: byte-wide data areas seen by the query handler
module mbr_area_model (
  input wire logic [8:0] area_addr,
  input wire logic area_sel_out,
  output logic [7:0] area_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // pattern differs per area and per byte so swapped bytes show
  assign area_rdata = area_addr[7:0] ^ {area_sel_out, area_addr[8], 6'h00};
endmodule : mbr_area_model

// File: tb/mbr_monitor.sv
// checker: reply timing and framing of the query handler
module mbr_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic [15:0] tx_port,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_exc; $rose(tx_valid) ##0 tx_data[7] ##0 tx_ready; endsequence
  sequence s_end; tx_valid && tx_last && tx_ready; endsequence
  property p_port; tx_port == 16'h01F6; endproperty
  a_port: assert property (p_port) else $error("reply port wrong");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped");
  property p_answer; $rose(tx_valid) |-> $past(rx_valid && rx_ready && rx_last, 2); endproperty
  a_answer: assert property (p_answer) else $error("reply not two cycles after query");
  property p_busy; tx_valid |-> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("query taken while replying");
  property p_last; tx_last |-> tx_valid; endproperty
  a_last: assert property (p_last) else $error("last without valid");
  property p_exc; s_exc |=> tx_last && tx_data inside {8'h01, 8'h02, 8'h03}; endproperty
  a_exc: assert property (p_exc) else $error("exception reply malformed");
  property p_func; $rose(tx_valid) |-> tx_data[7] || tx_data inside {8'h03, 8'h04}; endproperty
  a_func: assert property (p_func) else $error("unsupported function served");
  property p_single; s_end |=> !tx_valid ##1 !tx_valid; endproperty
  a_single: assert property (p_single) else $error("reply runs past last");
endmodule : mbr_monitor

// File: tb/tb.sv
// testbench: read queries, exceptions and dropped frames
`define CK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, rx_valid = 0, rx_last = 0, tx_ready = 0, ctl_stat_en = 0;
  logic [15:0] rx_port = 16'h01F6, in_size = 16'h0100, out_size = 16'h0200;
  logic [15:0] status_word = 16'h0A5C, control_word = 16'h3C81;
  logic [7:0] rx_data = 8'h00;
  logic rx_ready, tx_valid, tx_last, area_sel_out;
  logic [15:0] tx_port;
  logic [7:0] tx_data, area_rdata;
  logic [8:0] area_addr;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  logic [7:0] got[$], ex[$];
  logic [40:0] rows[10] = '{{1'b0, 8'h04, 16'h0001, 16'h0002}, {1'b1, 8'h03, 16'h0000, 16'h0003},
    {1'b1, 8'h04, 16'h0000, 16'h0001}, {1'b0, 8'h06, 16'h0000, 16'h0001}, {1'b0, 8'h03, 16'h0000, 16'h0000},
    {1'b0, 8'h03, 16'h0000, 16'h007E}, {1'b0, 8'h04, 16'h007F, 16'h0001}, {1'b0, 8'h04, 16'h0080, 16'h0001},
    {1'b0, 8'h03, 16'h00FF, 16'h0001}, {1'b0, 8'h03, 16'h00FF, 16'h0002}};
  mbr_server mbr_server_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .rx_port(rx_port),
    .rx_valid(rx_valid),
    .rx_last(rx_last),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .tx_port(tx_port),
    .tx_valid(tx_valid),
    .tx_last(tx_last),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .area_addr(area_addr),
    .area_sel_out(area_sel_out),
    .area_rdata(area_rdata),
    .in_size(in_size),
    .out_size(out_size),
    .ctl_stat_en(ctl_stat_en),
    .status_word(status_word),
    .control_word(control_word)
  );
  mbr_area_model mbr_area_model_i (
    .area_addr(area_addr),
    .area_sel_out(area_sel_out),
    .area_rdata(area_rdata)
  );
  initial forever #5 mclk = ~mclk;
  function automatic logic [7:0] mb(logic s, logic [8:0] a);
    return a[7:0] ^ {s, a[8], 6'h00};
  endfunction : mb
  task automatic end_of_test;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic send(input logic [7:0] v, input int cnt);
    int k;
    for (k = 0; k < cnt; k++) begin
      rx_valid <= 1'b1;
      rx_data <= v;
      rx_last <= (k == cnt - 1);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask : send
  task automatic xfer(input logic c, input logic [7:0] f, input logic [15:0] a, input logic [15:0] n);
    logic [7:0] b[5];
    int k;
    logic d;
    b = '{f, a[15:8], a[7:0], n[15:8], n[7:0]};
    got.delete();
    d = 0;
    @(posedge mclk);
    ctl_stat_en <= c;
    for (k = 0; k < 5; k++) begin
      rx_valid <= 1;
      rx_data <= b[k];
      rx_last <= (k == 4);
      @(posedge mclk);
    end
    rx_valid <= 0;
    rx_last <= 0;
    // stall every other cycle so held bytes get exercised
    for (k = 0; k < 60 && !d; k++) begin
      tx_ready <= ~tx_ready;
      @(negedge mclk);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        d = tx_last;
      end
      @(posedge mclk);
    end
  endtask : xfer
  initial begin
    logic c, sel;
    logic [7:0] f;
    logic [15:0] a, n, sz, w;
    int i, r;
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    @(negedge mclk);
    `CK("rx_ready", 1'b1, rx_ready)
    `CK("tx_valid", 1'b0, tx_valid)
    `CK("tx_port", 16'h01F6, tx_port)
    for (i = 0; i < 10; i++) begin
      {c, f, a, n} = rows[i];
      sel = (f == 8'h03);
      sz = sel ? out_size : in_size;
      if (f != 8'h03 && f != 8'h04) ex = '{f | 8'h80, 8'h01};
      else if (n < 16'h0001 || n > 16'h007D) ex = '{f | 8'h80, 8'h03};
      else if (a + n > 16'h0100 || (a + n) * 2 > sz) ex = '{f | 8'h80, 8'h02};
      else begin
        ex = '{f, n[6:0] * 8'h02};
        for (r = a; r < a + n; r++) begin
          w = (c && r == 0) ? (sel ? control_word : status_word) : {mb(sel, 9'(2 * r + 1)), mb(sel, 9'(2 * r))};
          ex.push_back(w[15:8]);
          ex.push_back(w[7:0]);
        end
      end
      xfer(c, f, a, n);
      `CK("length", ex.size(), got.size())
      for (r = 0; r < ex.size(); r++) `CK("byte", ex[r], got[r])
      $display("row %0d done", i);
    end
    rx_port <= 16'h01F7;
    xfer(1'b0, 8'h04, 16'h0000, 16'h0001);
    `CK("dropped", 0, got.size())
    $display("port test done");
    rx_port <= 16'h01F6;
    tx_ready <= 1'b0;
    send(8'h04, 6);
    repeat (4) @(negedge mclk);
    `CK("long frame", 1'b0, tx_valid)
    $display("long frame done");
    @(posedge mclk);
    send(8'h03, 5);
    repeat (3) @(negedge mclk);
    `CK("exc up", 1'b1, tx_valid)
    `CK("exc func", 8'h83, tx_data)
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    `CK("rx_ready reset", 1'b1, rx_ready)
    `CK("tx_valid reset", 1'b0, tx_valid)
    xfer(1'b0, 8'h04, 16'h0002, 16'h0001);
    `CK("after reset", 4, got.size())
    `CK("after reset func", 8'h04, got[0])
    $display("reset test done");
    end_of_test;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
endmodule : tb
bind mbr_server mbr_monitor mbr_monitor_i (
  .mclk(mclk),
  .rst_n(rst_n),
  .rx_valid(rx_valid),
  .rx_last(rx_last),
  .rx_ready(rx_ready),
  .tx_port(tx_port),
  .tx_valid(tx_valid),
  .tx_last(tx_last),
  .tx_data(tx_data),
  .tx_ready(tx_ready)
);
